// ==== core/wdg_defs.svh ====
/*
 Constants of the watchdog block: register offsets, bit positions, field
 limits and timing figures. Included by bare name from core files.
*/
`ifndef WDG_DEFS_SVH
`define WDG_DEFS_SVH
`define WDG_ADDR_W 4
`define WDG_OFF_CAUSE 4'h0
`define WDG_OFF_CTRL 4'h4
`define WDG_OFF_CMD 4'h8
`define WDG_CAUSE_POWERON 0
`define WDG_CAUSE_PIN 1
`define WDG_CAUSE_BROWNOUT 2
`define WDG_CAUSE_DOG 3
`define WDG_CTRL_PSC0 0
`define WDG_CTRL_PSC1 1
`define WDG_CTRL_PSC2 2
`define WDG_CTRL_RST_EN 3
`define WDG_CTRL_CHG_EN 4
`define WDG_CTRL_PSC3 5
`define WDG_CTRL_IRQ_EN 6
`define WDG_CTRL_IRQ_FLAG 7
`define WDG_CMD_RESTART 0
`define WDG_CMD_VECTOR 1
`define WDG_CHG_WINDOW 3'h4
`define WDG_PSC_MAX 4'h9
`define WDG_BASE_CYCLES_LOG2 11
`define WDG_SYS_HZ 10000000
`define WDG_OSC_HZ 128000
`endif

// ==== core/wdg_pkg.sv ====
/*
 Types shared by the watchdog files.
 Assumes wdg_defs.svh is on the include path.
*/
`default_nettype none
package wdg_pkg;
   typedef struct packed {
      logic [7:0] dat;
      logic [3:0] adr;
      logic [3:0] sel;
      logic we;
   } wdg_req_type;
   typedef enum logic [2:0] {
      WDG_ST_IDLE = 3'b001,
      WDG_ST_ACK = 3'b010,
      WDG_ST_GAP = 3'b100
   } wdg_bus_state_type;
endpackage
`default_nettype wire

// ==== core/wdg_ticker.sv ====
/*
 Oscillator tick generator: divides the system clock to one-cycle enable
 pulses at the watchdog oscillator rate.
 Assumes a single free-running system clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wdg_defs.svh"
module wdg_ticker #(
   parameter int SYS_HZ = `WDG_SYS_HZ,
   parameter int OSC_HZ = `WDG_OSC_HZ
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   output logic o_tick
);
   // Integer division loses some rate; exact oscillator accuracy is not kept.
   localparam int DIV = (SYS_HZ / OSC_HZ < 1) ? 1 : SYS_HZ / OSC_HZ;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic next_tick;
   always_comb begin
      next_tick = (cnt == 8'(DIV - 1));
      next_cnt = next_tick ? 8'h00 : cnt + 8'h01;
   end
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 8'h00;
         o_tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_tick <= next_tick;
      end
   end
endmodule // wdg_ticker
`default_nettype wire

// ==== core/wdg_top.sv ====
/*
 Watchdog timer with reset-cause flags, reached over classic Wishbone.
 Assumes the surrounding reset logic reports reset causes as pulses and
 that the core signals restart and interrupt vectoring as pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "wdg_defs.svh"
module wdg_top #(
   parameter int SYS_HZ = `WDG_SYS_HZ,
   parameter int OSC_HZ = `WDG_OSC_HZ,
   parameter int CNT_W = 21
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_poweron_rst,
   input wire logic i_brownout_rst,
   input wire logic i_pin_rst,
   input wire logic i_always_on_fuse,
   input wire logic i_restart,
   input wire logic i_vector,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_dog_irq,
   output logic o_dog_reset,
   output logic o_startup_start
);
   ////////////////////////////////////////////////////////////////////////
   logic poweron_s1, poweron_s2, brown_s1, brown_s2, pin_s1, pin_s2;
   logic fuse_s1, fuse_s2;
   logic osc_tick;
   wdg_pkg::wdg_req_type req;
   wdg_pkg::wdg_bus_state_type bus_st, next_bus_st;
   logic [3:0] cause, next_cause;
   logic irq_flag, next_irq_flag;
   logic irq_en, next_irq_en;
   logic rst_en_q, next_rst_en_q;
   logic [3:0] psc, next_psc;
   logic [2:0] chg_cnt, next_chg_cnt;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic next_dog_reset, next_startup, next_irq_out;
   logic [31:0] next_rdat;
   logic next_ack;
   logic wr_cause, wr_ctrl, wr_cmd, take;
   logic eff_rst_en, eff_irq_en, expire, chg_open;
   logic [CNT_W-1:0] limit;

   // Pin-side levels pass two flip-flops before any use.
   // The fuse is a level too, so it is treated like any other pin.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         {poweron_s1, poweron_s2, brown_s1, brown_s2} <= 4'h0;
         {pin_s1, pin_s2, fuse_s1, fuse_s2} <= 4'h0;
      end else begin
         poweron_s1 <= i_poweron_rst;
         poweron_s2 <= poweron_s1;
         brown_s1 <= i_brownout_rst;
         brown_s2 <= brown_s1;
         pin_s1 <= i_pin_rst;
         pin_s2 <= pin_s1;
         fuse_s1 <= i_always_on_fuse;
         fuse_s2 <= fuse_s1;
      end
   end

   wdg_ticker #(
      .SYS_HZ(SYS_HZ),
      .OSC_HZ(OSC_HZ)
   ) u_ticker (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .o_tick(osc_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: ack one cycle after the request, then one gap cycle.
   // The gap cycle keeps a held request from being taken a second time.
   always_comb begin
      req.dat = i_wb_dat[7:0];
      req.adr = i_wb_adr;
      req.sel = i_wb_sel;
      req.we = i_wb_we;
      take = (bus_st == wdg_pkg::WDG_ST_IDLE) && i_wb_cyc && i_wb_stb;
      wr_cause = take && req.we && req.sel[0] &&
         (req.adr == `WDG_OFF_CAUSE);
      wr_ctrl = take && req.we && req.sel[0] && (req.adr == `WDG_OFF_CTRL);
      wr_cmd = take && req.we && req.sel[0] && (req.adr == `WDG_OFF_CMD);
      next_ack = take;
      unique case (bus_st)
         wdg_pkg::WDG_ST_IDLE: next_bus_st = take ? wdg_pkg::WDG_ST_ACK :
            wdg_pkg::WDG_ST_IDLE;
         wdg_pkg::WDG_ST_ACK: next_bus_st = wdg_pkg::WDG_ST_GAP;
         wdg_pkg::WDG_ST_GAP: next_bus_st = wdg_pkg::WDG_ST_IDLE;
         default: next_bus_st = wdg_pkg::WDG_ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode, limit and expiry.
   // Effective enables combine the stored bits with the fuse; reset enable also with the dog flag.
   always_comb begin
      eff_rst_en = rst_en_q || cause[`WDG_CAUSE_DOG] || fuse_s2;
      eff_irq_en = irq_en && !fuse_s2;
      // 16 ms to 8 s range
      limit = CNT_W'(1) << (`WDG_BASE_CYCLES_LOG2 + 32'(psc));
      // stopped mode
      // A count already past a newly shortened limit expires on the next oscillator tick.
      expire = osc_tick && (eff_rst_en || eff_irq_en) &&
         (cnt >= limit - CNT_W'(1));
      chg_open = (chg_cnt != 3'h0);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of the counter, flags and control bits.
   always_comb begin
      next_cnt = cnt;
      next_dog_reset = 1'b0;
      next_irq_flag = irq_flag;
      next_irq_en = irq_en;
      next_rst_en_q = rst_en_q;
      next_psc = psc;
      next_chg_cnt = chg_cnt;
      next_cause = cause;
      if (chg_open) begin
         next_chg_cnt = chg_cnt - 3'h1;
      end
      if (i_restart) begin
         next_cnt = '0;
      end else if (osc_tick && (eff_rst_en || eff_irq_en)) begin
         next_cnt = expire ? '0 : cnt + CNT_W'(1);
      end
      // Flag writes: software may clear, hardware event wins the same cycle.
      if (wr_cause) begin
         next_cause = cause & req.dat[3:0];
      end
      if (wr_ctrl && req.dat[`WDG_CTRL_IRQ_FLAG]) begin
         next_irq_flag = 1'b0;
      end
      if (wr_ctrl) begin
         next_irq_en = req.dat[`WDG_CTRL_IRQ_EN];
         // unlock needs change and reset enable together
         if (req.dat[`WDG_CTRL_CHG_EN] && req.dat[`WDG_CTRL_RST_EN]) begin
            next_chg_cnt = `WDG_CHG_WINDOW;
            next_rst_en_q = 1'b1;
         end else if (chg_open && !req.dat[`WDG_CTRL_CHG_EN]) begin
            next_rst_en_q = req.dat[`WDG_CTRL_RST_EN] ||
               cause[`WDG_CAUSE_DOG];
            next_psc = {req.dat[`WDG_CTRL_PSC3], req.dat[`WDG_CTRL_PSC2],
               req.dat[`WDG_CTRL_PSC1], req.dat[`WDG_CTRL_PSC0]};
            next_chg_cnt = 3'h0;
         end else if (req.dat[`WDG_CTRL_RST_EN]) begin
            next_rst_en_q = 1'b1;
         end
      end
      // Reserved prescaler codes saturate at the longest period.
      if (next_psc > `WDG_PSC_MAX) begin
         next_psc = `WDG_PSC_MAX;
      end
      if ((wr_cmd && req.dat[`WDG_CMD_VECTOR]) || i_vector) begin
         next_irq_flag = 1'b0;
         if (eff_rst_en) begin
            next_irq_en = 1'b0;
         end
      end
      if (expire && eff_irq_en) begin
         next_irq_flag = 1'b1;
      end
      if (expire && eff_rst_en && !eff_irq_en) begin
         next_dog_reset = 1'b1;
         next_cause[`WDG_CAUSE_DOG] = 1'b1;
         next_rst_en_q = 1'b1;
      end
      if (wr_cmd && req.dat[`WDG_CMD_RESTART]) begin
         next_cnt = '0;
      end
      if (brown_s2) begin
         next_cause[`WDG_CAUSE_BROWNOUT] = 1'b1;
      end
      if (pin_s2) begin
         next_cause[`WDG_CAUSE_PIN] = 1'b1;
      end
      if (poweron_s2) begin
         next_cause = 4'h1;
      end
      next_startup = o_dog_reset && !next_dog_reset;
      next_irq_out = next_irq_flag && next_irq_en && !fuse_s2;
      // Read data stand only in the answer cycle and are zero otherwise.
      next_rdat = 32'h0;
      if (take) begin
         unique case (req.adr)
            `WDG_OFF_CAUSE: next_rdat = {28'h0, cause};
            `WDG_OFF_CTRL: next_rdat = {24'h0, irq_flag, eff_irq_en, psc[3],
               chg_open, eff_rst_en, psc[2:0]};
            default: next_rdat = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer registers.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         bus_st <= wdg_pkg::WDG_ST_IDLE;
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
      end else begin
         bus_st <= next_bus_st;
         o_wb_ack <= next_ack;
         o_wb_dat <= next_rdat;
      end
   end

   // Status and control registers.
   // The async reset is the logic's own power-up and clears the cause flags.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cause <= 4'h0;
         irq_flag <= 1'b0;
         irq_en <= 1'b0;
         rst_en_q <= 1'b0;
         psc <= 4'h0;
         chg_cnt <= 3'h0;
      end else begin
         cause <= next_cause;
         irq_flag <= next_irq_flag;
         irq_en <= next_irq_en;
         rst_en_q <= next_rst_en_q;
         psc <= next_psc;
         chg_cnt <= next_chg_cnt;
      end
   end

   // Counter and event outputs. Every output leaves a flip-flop, so each
   // pulse follows its cause by one cycle.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt <= '0;
         o_dog_reset <= 1'b0;
         o_startup_start <= 1'b0;
         o_dog_irq <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_dog_reset <= next_dog_reset;
         o_startup_start <= next_startup;
         o_dog_irq <= next_irq_out;
      end
   end
endmodule // wdg_top
`default_nettype wire

// ==== verification/wdg_core_model.sv ====
/*
 Model of the processor core beside the watchdog: turns bench requests
 into one-cycle restart and vector pulses.
 Assumes the bench holds each request for one clock cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module wdg_core_model (
   input wire logic i_clk_sys,
   input wire logic i_do_restart,
   input wire logic i_do_vector,
   output logic o_restart,
   output logic o_vector
);
   // restart and vector pulses.
   // Requests come well before expiry, so a restart never races a time-out.
   always_ff @(posedge i_clk_sys) begin
      o_restart <= i_do_restart;
      o_vector <= i_do_vector;
   end
endmodule // wdg_core_model
`default_nettype wire

// ==== verification/wdg_top_sva.sv ====
/*
 Port checker of the watchdog block.
 Assumes it is bound into wdg_top.
*/
`timescale 1ns/1ns
`default_nettype none
module wdg_top_sva (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_always_on_fuse,
   input wire logic i_restart,
   input wire logic i_vector,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire logic o_dog_irq,
   input wire logic o_dog_reset,
   input wire logic o_startup_start
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   property p_pulse; o_dog_reset |=> !o_dog_reset; endproperty
   a_pulse: assert property (p_pulse)
      else $error("reset pulse too long");
   property p_start; o_dog_reset |=> o_startup_start; endproperty
   a_start: assert property (p_start)
      else $error("start-up delay not begun");
   property p_cause; o_startup_start |-> $past(o_dog_reset); endproperty
   a_cause: assert property (p_cause)
      else $error("start-up delay without reset pulse");
   property p_restart; i_restart |-> ##2 !o_dog_reset [*6]; endproperty
   a_restart: assert property (p_restart)
      else $error("reset right after restart");
   property p_fuse; i_always_on_fuse [*4] |-> !o_dog_irq; endproperty
   a_fuse: assert property (p_fuse)
      else $error("interrupt under fuse");
   property p_vector; i_vector |-> ##[1:3] !o_dog_irq; endproperty
   a_vector: assert property (p_vector)
      else $error("interrupt kept after vectoring");
   property p_irq; $rose(o_dog_irq) |-> !o_dog_reset [*3]; endproperty
   a_irq: assert property (p_irq)
      else $error("reset together with interrupt");
   property p_ack;
      o_wb_ack |-> $past(i_wb_cyc && i_wb_stb) ##1 !o_wb_ack;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bad bus acknowledge");
endmodule // wdg_top_sva
bind wdg_top wdg_top_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_always_on_fuse(i_always_on_fuse), .i_restart(i_restart),
   .i_vector(i_vector), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .o_wb_ack(o_wb_ack), .o_dog_irq(o_dog_irq), .o_dog_reset(o_dog_reset),
   .o_startup_start(o_startup_start));
`default_nettype wire

// ==== verification/testbench.sv ====
/*
 Self-checking bench of the watchdog with reset-cause flags.
 Assumes the design, core model and checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic por = 1'b0, bor = 1'b0, pin = 1'b0, fuse = 1'b0;
   logic do_rs = 1'b0, do_vec = 1'b0, restart, vector;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, dres, sst;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic [7:0] exp_q[$];
   logic [7:0] r;
   int bad_count = 0;
   int n_compared = 0;
   int rst_cnt = 0;
   int sst_cnt = 0;
   int waited = 0;
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   // Tick every cycle, so code zero expires after 2048 cycles.
   wdg_top #(.SYS_HZ(1000000), .OSC_HZ(1000000)) DUT (.i_clk_sys(clk),
      .i_rst(rst), .i_poweron_rst(por), .i_brownout_rst(bor),
      .i_pin_rst(pin), .i_always_on_fuse(fuse), .i_restart(restart),
      .i_vector(vector), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .o_dog_irq(irq), .o_dog_reset(dres),
      .o_startup_start(sst));
   wdg_core_model u_core (.i_clk_sys(clk), .i_do_restart(do_rs),
      .i_do_vector(do_vec), .o_restart(restart), .o_vector(vector));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h000000, d};
      do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
      {cyc, stb} <= 2'b00;
      if (n >= 20) chk("bus ack", 32'h1, 32'h0);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 8'h00);
   endtask
   task automatic core(input logic v);
      @(posedge clk);
      {do_rs, do_vec} <= {~v, v};
      @(posedge clk);
      {do_rs, do_vec} <= 2'b00;
   endtask
   task automatic ev(input logic [2:0] m);
      @(posedge clk);
      {por, pin, bor} <= m;
      repeat (2) @(posedge clk);
      {por, pin, bor} <= 3'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic wait_ev(input bit for_rst, input int c0);
      int n;
      n = 0;
      while ((for_rst ? rst_cnt == c0 : irq !== 1'b1) && n < 5000) begin
         @(posedge clk);
         n++;
      end
      waited = n;
      chk("event wait", 32'h1, {31'h00000000, n < 5000});
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (dres === 1'b1) rst_cnt <= rst_cnt + 1;
      if (sst === 1'b1) sst_cnt <= sst_cnt + 1;
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         chk("read data", {24'h000000, exp_q.pop_front()}, rdat);
      end
   end
   initial begin
      void'($urandom(36791));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      ev(3'b100);
      ev(3'b011);
      rd(4'h0, 8'h07);
      r = 8'($urandom);
      wb(1'b1, 4'h0, r);
      rd(4'h0, 8'h07 & r);
      wb(1'b1, 4'h0, 8'h00);
      rd(4'hc, 8'h00);
      rd(4'h0, 8'h00);
      wb(1'b1, 4'h4, 8'h48);
      core(1'b0);
      wait_ev(1'b0, 0);
      chk("reset count", 32'h0, rst_cnt);
      core(1'b1);
      wait_ev(1'b1, 0);
      rd(4'h0, 8'h08);
      rd(4'h4, 8'h08);
      core(1'b0);
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h08);
      wb(1'b1, 4'h0, 8'h00);
      wb(1'b1, 4'h4, 8'h18);
      repeat (6) @(posedge clk);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h08);
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h00);
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h27);
      rd(4'h4, 8'h21);
      wb(1'b1, 4'h4, 8'h18);
      wb(1'b1, 4'h4, 8'h00);
      wb(1'b1, 4'h4, 8'h40);
      wait_ev(1'b0, 0);
      chk("reset count", 32'h1, rst_cnt);
      wb(1'b1, 4'h8, 8'h02);
      rd(4'h4, 8'h40);
      wb(1'b1, 4'h8, 8'h01);
      wait_ev(1'b0, 0);
      chk("period", 32'h800, waited);
      wb(1'b1, 4'h4, 8'hc0);
      rd(4'h4, 8'h40);
      wb(1'b1, 4'h4, 8'h00);
      fuse <= 1'b1;
      repeat (5) @(posedge clk);
      rd(4'h4, 8'h08);
      wait_ev(1'b1, 1);
      repeat (2) @(posedge clk);
      chk("reset count", 32'h2, rst_cnt);
      chk("start-up count", 32'h2, sst_cnt);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule // testbench
`default_nettype wire
